// *** pcibic_defs.svh ***
// Behaviour
// (R01) The upper half of configuration dword 00h returns a fixed 16-bit device code, and writes to it change nothing.
// (R02) Command bit 0 at dword 04h is a read/write I/O enable, reset to zero, without which primary I/O cycles are ignored.
// (R03) Command bit 1 is a read/write memory enable, reset to zero, without which primary memory cycles are ignored.
// (R04) With command bit 2 clear the bridge never masters the primary bus and ignores secondary memory and I/O cycles;
// the code drops only a forwarded cycle still waiting for grant, and one already granted runs on until pri_mdone_i.
// (R05) With command bit 2 set the bridge may master the primary bus to carry cycles forwarded from the secondary side.
// (R06) The special-cycle bit of the command register is read-only and always reads as zero.
// (R07) The registers sit in a 64-byte header reached by configuration cycles from the primary side.
// (R08) Writes leave read-only fields unchanged while writable command bits follow the byte enables.
`ifndef PCIBIC_DEFS_SVH
`define PCIBIC_DEFS_SVH

// Header space, byte addressed, dword aligned
`define PCIBIC_SPACE_BYTES 64
`define PCIBIC_ADDR_W 6
`define PCIBIC_OFF_ID 6'h00
`define PCIBIC_OFF_CMD 6'h04

// Field positions in the identity dword
`define PCIBIC_DEVID_HI 31
`define PCIBIC_DEVID_LO 16

// Command bit positions
`define PCIBIC_CMD_IO 0
`define PCIBIC_CMD_MEM 1
`define PCIBIC_CMD_BME 2
`define PCIBIC_CMD_SPC 3

// Command low byte reset value and writable mask
`define PCIBIC_CMD_RST 8'h00
`define PCIBIC_CMD_WMASK 8'h07

// Byte lane carrying the command low byte
`define PCIBIC_CMD_LANE 0

`endif

// *** pcibic_pkg.sv ***
package pcibic_pkg;

  // Configuration access from the primary target logic
  typedef struct packed {
    logic valid;
    logic write;
    logic [5:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } pcibic_cfg_req_t;

  // Configuration answer
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } pcibic_cfg_rsp_t;

  // Cycle seen on one bus, already address-decoded
  typedef struct packed {
    logic valid;
    logic is_io;
    logic [31:0] addr;
  } pcibic_cyc_t;

  // Configuration access sequencer
  typedef enum logic [0:0] {
    PCIBIC_CFG_IDLE = 1'b0,
    PCIBIC_CFG_RESP = 1'b1
  } pcibic_cfg_state_t;

  // Primary master sequencer for forwarded cycles
  typedef enum logic [1:0] {
    PCIBIC_FWD_IDLE = 2'b00,
    PCIBIC_FWD_REQ = 2'b01,
    PCIBIC_FWD_XFER = 2'b11,
    PCIBIC_FWD_DONE = 2'b10
  } pcibic_fwd_state_t;

endpackage

// *** pcibic_byte_reg.sv ***
`include "pcibic_defs.svh"

module pcibic_byte_reg #(
  parameter int W = 8,
  parameter logic [W-1:0] RST = '0,
  parameter logic [W-1:0] WMASK = '1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic we_i,
  input wire logic [W-1:0] wdata_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] q_q;
  logic [W-1:0] q_d;

  // Masked bits keep their reset value for good
  assign q_d = (q_q & ~WMASK) | (wdata_i & WMASK);
  assign q_o = q_q;

  // Storage, synchronous reset
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      q_q <= RST;
    end else if (we_i) begin
      q_q <= q_d;
    end
  end

endmodule

// *** pcibic_cfg_regs.sv ***
`include "pcibic_defs.svh"

module pcibic_cfg_regs
  import pcibic_pkg::*;
#(
  parameter logic [15:0] DEVICE_CODE = 16'h0002, // Arbitrary value
  parameter logic [15:0] MAKER_CODE = 16'h0001 // Arbitrary value
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Configuration access
  input wire pcibic_cfg_req_t cfg_req_i,
  output logic cfg_ready_o,
  output pcibic_cfg_rsp_t cfg_rsp_o,
  // Primary target cycles, address already decoded as ours
  input wire pcibic_cyc_t pri_cyc_i,
  output logic pri_claim_o,
  // Secondary target cycles to be forwarded upstream
  input wire pcibic_cyc_t sec_cyc_i,
  output logic sec_claim_o,
  output logic sec_done_o,
  output logic sec_abort_o,
  // Primary master side
  output logic pri_mreq_o,
  output pcibic_cyc_t pri_mcyc_o,
  input wire logic pri_gnt_i,
  input wire logic pri_mdone_i,
  // Enable levels for the rest of the bridge
  output logic io_en_o,
  output logic mem_en_o,
  output logic master_en_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  pcibic_cfg_state_t cfg_state_q;
  pcibic_cfg_state_t cfg_state_d;
  pcibic_fwd_state_t fwd_state_q;
  pcibic_fwd_state_t fwd_state_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic ack_q;
  pcibic_cyc_t fwd_cyc_q;
  logic done_q;
  logic abort_q;

  logic cfg_take;
  logic hit_id;
  logic hit_cmd;
  logic cmd_we;
  logic [7:0] cmd_wbyte;
  logic [7:0] cmd_byte;
  logic [31:0] id_dword;
  logic [31:0] cmd_dword;
  logic io_en;
  logic mem_en;
  logic bme;
  logic sec_take;
  logic fwd_idle;

  // Register offsets as sized constants, so their dword bits can be picked
  localparam logic [`PCIBIC_ADDR_W-1:0] OFF_ID = `PCIBIC_OFF_ID;
  localparam logic [`PCIBIC_ADDR_W-1:0] OFF_CMD = `PCIBIC_OFF_CMD;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration decode

  // One access in flight; answer in the cycle after it is taken
  assign cfg_ready_o = (cfg_state_q == PCIBIC_CFG_IDLE);
  assign cfg_take = cfg_req_i.valid && cfg_ready_o;

  // Only the dword index selects a register in the 64-byte header
  // (R07) header dword decode
  assign hit_id = cfg_req_i.addr[`PCIBIC_ADDR_W-1:2] ==
                  OFF_ID[`PCIBIC_ADDR_W-1:2];
  assign hit_cmd = cfg_req_i.addr[`PCIBIC_ADDR_W-1:2] ==
                   OFF_CMD[`PCIBIC_ADDR_W-1:2];

  // Writes to the identity dword have no target at all
  // (R08) byte enable gating
  assign cmd_we = cfg_take && cfg_req_i.write && hit_cmd &&
                  cfg_req_i.be[`PCIBIC_CMD_LANE];
  assign cmd_wbyte = cfg_req_i.wdata[`PCIBIC_CMD_LANE*8 +: 8];

  ////////////////////////////////////////////////////////////////////////////
  // Command low byte

  // (R06) special cycle read zero
  // (R08) read-only bits kept
  pcibic_byte_reg #(
    .W(8),
    .RST(`PCIBIC_CMD_RST),
    .WMASK(`PCIBIC_CMD_WMASK)
  ) u_cmd_lo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .we_i(cmd_we),
    .wdata_i(cmd_wbyte),
    .q_o(cmd_byte)
  );

  // Individual enables
  // (R02) I/O enable bit
  assign io_en = cmd_byte[`PCIBIC_CMD_IO];
  // (R03) memory enable bit
  assign mem_en = cmd_byte[`PCIBIC_CMD_MEM];
  // (R05) master enable bit
  assign bme = cmd_byte[`PCIBIC_CMD_BME];

  assign io_en_o = io_en;
  assign mem_en_o = mem_en;
  assign master_en_o = bme;

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  // (R01) fixed device code
  assign id_dword = {DEVICE_CODE, MAKER_CODE};
  // Status half and upper command byte are outside this block, read zero
  assign cmd_dword = {24'h000000, cmd_byte};

  // Unmapped dwords read zero
  assign rdata_d = hit_id ? id_dword :
                   hit_cmd ? cmd_dword :
                   32'h00000000;

  // Configuration sequencer next state
  always_comb begin
    cfg_state_d = cfg_state_q;
    unique case (cfg_state_q)
      PCIBIC_CFG_IDLE: begin
        if (cfg_take) begin
          cfg_state_d = PCIBIC_CFG_RESP;
        end
      end
      PCIBIC_CFG_RESP: begin
        cfg_state_d = PCIBIC_CFG_IDLE;
      end
    endcase
  end

  // Answer registers; read data held until the next read answer
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cfg_state_q <= PCIBIC_CFG_IDLE;
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      cfg_state_q <= cfg_state_d;
      ack_q <= cfg_take;
      if (cfg_take && !cfg_req_i.write) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // One driver for the whole answer struct
  assign cfg_rsp_o = '{ack: ack_q, rdata: rdata_q};

  ////////////////////////////////////////////////////////////////////////////
  // Primary target gating

  // Claim only the cycle types whose space is enabled
  // (R02) ignore I/O when off
  // (R03) ignore memory when off
  assign pri_claim_o = pri_cyc_i.valid &&
                       (pri_cyc_i.is_io ? io_en : mem_en);

  ////////////////////////////////////////////////////////////////////////////
  // Secondary forwarding and primary mastering

  assign fwd_idle = (fwd_state_q == PCIBIC_FWD_IDLE);

  // Secondary cycles are claimed only with mastering enabled
  // (R04) secondary claim gated
  assign sec_take = sec_cyc_i.valid && bme && fwd_idle;
  assign sec_claim_o = sec_take;

  // Forwarding sequencer next state
  always_comb begin
    fwd_state_d = fwd_state_q;
    unique case (fwd_state_q)
      PCIBIC_FWD_IDLE: begin
        if (sec_take) begin
          fwd_state_d = PCIBIC_FWD_REQ;
        end
      end
      PCIBIC_FWD_REQ: begin
        // (R04) drop request if disabled
        if (!bme) begin
          fwd_state_d = PCIBIC_FWD_IDLE;
        end else if (pri_gnt_i) begin
          fwd_state_d = PCIBIC_FWD_XFER;
        end
      end
      PCIBIC_FWD_XFER: begin
        if (pri_mdone_i) begin
          fwd_state_d = PCIBIC_FWD_DONE;
        end
      end
      PCIBIC_FWD_DONE: begin
        fwd_state_d = PCIBIC_FWD_IDLE;
      end
    endcase
  end

  // Forwarding registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fwd_state_q <= PCIBIC_FWD_IDLE;
      fwd_cyc_q <= '0;
      done_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      fwd_state_q <= fwd_state_d;
      if (sec_take) begin
        fwd_cyc_q <= sec_cyc_i;
      end
      done_q <= (fwd_state_q == PCIBIC_FWD_XFER) && pri_mdone_i;
      abort_q <= (fwd_state_q == PCIBIC_FWD_REQ) && !bme;
    end
  end

  // Bus request asserted only while mastering is enabled
  // (R05) master when enabled
  // (R04) no master when off
  assign pri_mreq_o = (fwd_state_q == PCIBIC_FWD_REQ) && bme;
  assign pri_mcyc_o = fwd_cyc_q;
  assign sec_done_o = done_q;
  assign sec_abort_o = abort_q;

endmodule

// *** pcibic_checker.sv ***
module pcibic_checker
  import pcibic_pkg::*;
#(
  parameter logic [15:0] DEVICE_CODE = 16'h0002 // Arbitrary value
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire pcibic_cfg_req_t cfg_req_i,
  input wire logic cfg_ready_o,
  input wire pcibic_cfg_rsp_t cfg_rsp_o,
  input wire pcibic_cyc_t pri_cyc_i,
  input wire logic pri_claim_o,
  input wire logic sec_claim_o,
  input wire logic pri_mreq_o,
  input wire logic io_en_o,
  input wire logic mem_en_o,
  input wire logic master_en_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Taken accesses and the enable levels
  wire take = cfg_req_i.valid && cfg_ready_o;
  wire [3:0] dw = cfg_req_i.addr[5:2];
  wire [2:0] en = {master_en_o, mem_en_o, io_en_o};
  sequence s_rd(a); take && !cfg_req_i.write && dw == a; endsequence
  sequence s_cw; take && cfg_req_i.write && dw == 4'h1; endsequence
  property p_id; s_rd(4'h0) |=> cfg_rsp_o.rdata[31:16] == DEVICE_CODE;
  endproperty
  property p_claim; pri_cyc_i.valid |->
    pri_claim_o == (pri_cyc_i.is_io ? io_en_o : mem_en_o); endproperty
  property p_rst; $rose(rst_n_i) |-> en == 3'h0; endproperty
  property p_nomst; !master_en_o |-> !pri_mreq_o && !sec_claim_o;
  endproperty
  property p_fwd; sec_claim_o ##1 master_en_o |-> pri_mreq_o; endproperty
  property p_spc; s_rd(4'h1) |=> cfg_rsp_o.rdata[31:3] == 29'h0;
  endproperty
  property p_ack; take |=> cfg_rsp_o.ack && !cfg_ready_o ##1
    !cfg_rsp_o.ack; endproperty
  property p_wr; s_cw |=> en == ($past(cfg_req_i.be[0]) ?
    $past(cfg_req_i.wdata[2:0]) : $past(en)); endproperty
  a_id: assert property (p_id) else $error("bad device code");
  a_claim: assert property (p_claim) else $error("bad claim");
  a_rst: assert property (p_rst) else $error("enables set");
  a_nomst: assert property (p_nomst) else $error("master off");
  a_fwd: assert property (p_fwd) else $error("no request");
  a_spc: assert property (p_spc) else $error("bit 3 set");
  a_ack: assert property (p_ack) else $error("bad answer");
  a_wr: assert property (p_wr) else $error("bad command");
endmodule

// *** pcibic_host_model.sv ***
module pcibic_host_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic mreq_i,
  input wire logic [2:0] dly_i,
  output logic gnt_o,
  output logic mdone_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] cnt_q;
  logic xfer_q;
  wire hit = cnt_q == dly_i && !gnt_o;
  // Grant a request, then end the transfer, each after dly_i cycles, except that the end waits 8 cycles when dly_i is 0
  always_ff @(posedge clk_i) begin
    gnt_o <= 1'b0;
    mdone_o <= 1'b0;
    cnt_q <= (mreq_i || xfer_q) ? cnt_q + 3'h1 : 3'h0;
    if (!rst_n_i) begin
      xfer_q <= 1'b0;
      cnt_q <= 3'h0;
    end else if (hit && mreq_i) begin
      gnt_o <= 1'b1;
      xfer_q <= 1'b1;
      cnt_q <= 3'h0;
    end else if (hit && xfer_q) begin
      mdone_o <= 1'b1;
      xfer_q <= 1'b0;
    end
  end
endmodule

// *** testbench.sv ***
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import pcibic_pkg::*;
  localparam logic [15:0] DEV = 16'h0002; // Arbitrary value
  localparam logic [15:0] MAK = 16'h0001; // Arbitrary value
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  pcibic_cfg_req_t cfg_req_i = '0;
  pcibic_cyc_t pri_cyc_i = '0;
  pcibic_cyc_t sec_cyc_i = '0;
  pcibic_cfg_rsp_t cfg_rsp_o;
  pcibic_cyc_t pri_mcyc_o;
  logic cfg_ready_o, pri_claim_o, sec_claim_o, sec_done_o, sec_abort_o;
  logic pri_mreq_o, pri_gnt_i, pri_mdone_i, io_en_o, mem_en_o, master_en_o;
  logic [2:0] dly = 3'h0;
  logic [2:0] cmd = 3'h0;
  logic [31:0] seed = 32'he41c8cfe;
  logic [31:0] d;
  logic [32:0] e;
  logic [32:0] exp_q[$];
  int n_fail = 0;
  int total_checks = 0;
  wire [3:0] obs = {sec_abort_o, sec_done_o, sec_claim_o, cfg_ready_o};
  wire [2:0] en3 = {master_en_o, mem_en_o, io_en_o};
  logic exp_c;
  pcibic_cfg_regs #(.DEVICE_CODE(DEV), .MAKER_CODE(MAK)) u_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_req_i(cfg_req_i),
    .cfg_ready_o(cfg_ready_o), .cfg_rsp_o(cfg_rsp_o),
    .pri_cyc_i(pri_cyc_i), .pri_claim_o(pri_claim_o),
    .sec_cyc_i(sec_cyc_i), .sec_claim_o(sec_claim_o),
    .sec_done_o(sec_done_o), .sec_abort_o(sec_abort_o),
    .pri_mreq_o(pri_mreq_o), .pri_mcyc_o(pri_mcyc_o),
    .pri_gnt_i(pri_gnt_i), .pri_mdone_i(pri_mdone_i),
    .io_en_o(io_en_o), .mem_en_o(mem_en_o), .master_en_o(master_en_o));
  pcibic_host_model u_host (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .mreq_i(pri_mreq_o), .dly_i(dly), .gnt_o(pri_gnt_i),
    .mdone_o(pri_mdone_i));
  initial forever #5 clk_i = ~clk_i;
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input string nm, input logic [31:0] s, x);
    total_checks++;
    if (s !== x) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wait_on(input int b);
    repeat (64) begin
      @(negedge clk_i);
      if (obs[b] === 1'b1) return;
    end
    n_fail++;
    report_and_stop();
  endtask
  // One access, held until taken; reads note the expected dword
  task automatic cfg(input logic w, input logic [5:0] a,
    input logic [3:0] be, input logic [31:0] v);
    @(posedge clk_i);
    cfg_req_i <= '{1'b1, w, a, be, v};
    exp_q.push_back({!w, v});
    wait_on(0);
    @(posedge clk_i);
    cfg_req_i.valid <= 1'b0;
  endtask
  // One forwarded cycle, optionally dropped by clearing mastering
  task automatic fwd(input logic ab, input logic [2:0] dl);
    logic [31:0] a;
    a = rnd();
    @(posedge clk_i);
    dly <= dl;
    sec_cyc_i <= '{1'b1, a[0], a};
    wait_on(1);
    @(posedge clk_i);
    sec_cyc_i.valid <= 1'b0;
    if (ab) cfg(1'b1, 6'h04, 4'h1, 32'h0);
    wait_on(ab ? 3 : 2);
    check("fwd addr", pri_mcyc_o.addr, a);
    check("fwd io", {31'h0, pri_mcyc_o.is_io}, {31'h0, a[0]});
  endtask
  // Answers are matched against the oldest note
  always @(negedge clk_i) begin
    if (cfg_rsp_o.ack === 1'b1) begin
      e = exp_q.pop_front();
      if (e[32]) check("rdata", cfg_rsp_o.rdata, e[31:0]);
    end
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    cfg(1'b0, 6'h04, 4'hf, 32'h0);
    cfg(1'b1, 6'h00, 4'hf, 32'hffffffff);
    cfg(1'b0, 6'h00, 4'hf, {DEV, MAK});
    cfg(1'b0, 6'h3c, 4'hf, 32'h0);
    $display("identity test done");
    for (int i = 0; i < 16; i++) begin
      d = rnd();
      d[2:0] = i[2:0];
      cfg(1'b1, 6'h04, {3'h0, d[31]}, d);
      if (d[31]) cmd = i[2:0];
      cfg(1'b0, 6'h04, 4'hf, {29'h0, cmd});
      check("enables", {29'h0, en3}, {29'h0, cmd});
      pri_cyc_i <= '{1'b1, d[0], d};
      exp_c = d[0] ? cmd[0] : cmd[1];
      @(negedge clk_i);
      check("claim", {31'h0, pri_claim_o}, {31'h0, exp_c});
    end
    $display("command test done");
    cfg(1'b1, 6'h04, 4'h1, 32'h4);
    fwd(1'b0, 3'h0);
    fwd(1'b0, 3'h5);
    fwd(1'b1, 3'h7);
    @(posedge clk_i);
    sec_cyc_i <= '{1'b1, 1'b0, rnd()};
    repeat (4) begin
      @(negedge clk_i);
      check("master", {31'h0, sec_claim_o | pri_mreq_o}, 32'h0);
    end
    $display("forward test done");
    report_and_stop();
  end
endmodule
bind pcibic_cfg_regs pcibic_checker #(.DEVICE_CODE(DEVICE_CODE)) u_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_req_i(cfg_req_i),
  .cfg_ready_o(cfg_ready_o), .cfg_rsp_o(cfg_rsp_o),
  .pri_cyc_i(pri_cyc_i), .pri_claim_o(pri_claim_o),
  .sec_claim_o(sec_claim_o), .pri_mreq_o(pri_mreq_o),
  .io_en_o(io_en_o), .mem_en_o(mem_en_o), .master_en_o(master_en_o));
